//--- cpd_top.sv
// Capability permission decode and check engine with an AXI4-Lite register port
`default_nettype none

module cpd_top import cpd_pkg::*; #(
  parameter int MXLEN  = 32,
  parameter bit LEGACY = 1'b1
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [STRB_W-1:0] s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [DATA_W-1:0] s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output var  logic              access_fault
);

  // Capability geometry from the machine width; KEEP64 follows LEGACY and SLOT_W follows SLOTS
  localparam int          CAP_W   = 2 * MXLEN;
  localparam int          NWORDS  = CAP_W / DATA_W;
  localparam logic        WIDE    = (MXLEN == 64);
  localparam int          AP_W    = WIDE ? AP_W64 : AP_W32;
  localparam int          RSV_BIT = CAP_W - 1 - AP_W;
  localparam int          SLOT_W  = $clog2(SLOTS);
  localparam logic [5:0]  ROOT_AP = WIDE ? ROOT_AP64 : ROOT_AP32;
  localparam logic [5:0]  KEEP64  = LEGACY ? AP_ALL : AP64_NOMODE;

  logic [ADDR_W-1:0] aw_addr_q;
  logic              aw_have_q;
  logic [DATA_W-1:0] w_data_q;
  logic [STRB_W-1:0] w_strb_q;
  logic              w_have_q;
  logic              do_write;
  logic              wr_err;
  logic [DATA_W-1:0] rd_data;
  logic              rd_err;
  logic [CAP_W-1:0]  cap_q;
  logic              cap_tag_q;
  logic [CAP_W-1:0]  slot_q [SLOTS];
  logic              slot_tag_q [SLOTS];
  cpd_req_t          req_q;
  logic              start_q;
  cpd_status_t       status_q;
  logic [5:0]        ap_raw;
  cpd_grants_t       grants;
  logic              usable;
  logic              need_ok;
  logic              allowed;
  logic              is_access;
  logic [5:0]        ap_new;
  logic [SLOT_W-1:0] slot_idx;

  // Decode an encoded grant field into separate flags; reserved codes grant nothing
  function automatic cpd_grants_t cpd_decode(input logic [5:0] f, input logic wide, input logic legacy);
    cpd_grants_t g;
    g = GRANTS_NONE;
    if (wide) begin
      g.c    = f[0];
      g.w    = f[1];
      g.r    = f[2];
      g.x    = f[3];
      g.system_register_grant  = f[4];
      g.mode = legacy & f[5];
      g.rsv  = ~legacy & f[5];
    end else begin
      case (f[4:3])
        Q_DATA: begin
          case (f[2:0])
            3'h0: g = GRANTS_NONE;
            3'h1: g.r = 1'b1;
            3'h4: g.w = 1'b1;
            3'h5: begin
              g.r = 1'b1;
              g.w = 1'b1;
            end
            default: g.rsv = 1'b1;
          endcase
        end
        Q_EXEC: begin
          g.r    = 1'b1;
          g.x    = 1'b1;
          g.mode = legacy & f[0];
          case (f[2:1])
            2'h0: begin
              g.w   = 1'b1;
              g.c   = 1'b1;
              g.system_register_grant = 1'b1;
            end
            2'h1: g.c = 1'b1;
            2'h2: begin
              g.w = 1'b1;
              g.c = 1'b1;
            end
            default: g.w = 1'b1;
          endcase
        end
        Q_CAP: begin
          case (f[2:0])
            3'h3: begin
              g.r = 1'b1;
              g.c = 1'b1;
            end
            3'h7: begin
              g.r = 1'b1;
              g.w = 1'b1;
              g.c = 1'b1;
            end
            default: g.rsv = 1'b1;
          endcase
        end
        default: g.rsv = 1'b1;
      endcase
    end
    if (g.rsv) begin
      g = GRANTS_RSV;
    end
    return g;
  endfunction

  // Narrow the grant field to a legal code that is a subset of the wanted grants
  function automatic logic [5:0] restrict_ap(input logic [5:0] f, input logic [5:0] keep);
    cpd_grants_t want;
    cpd_grants_t g;
    logic [5:0]  pick;
    logic [2:0]  best;
    logic [2:0]  score;
    logic        fits;
    want = cpd_decode(f, WIDE, LEGACY);
    want = cpd_grants_t'({want.rsv, want.mode, want[4:0] & keep[4:0]});
    pick = '0;
    best = '0;
    if (WIDE) begin
      pick = f & keep & KEEP64;
    end else begin
      for (int i = 0; i < AP_CODES32; i++) begin
        g     = cpd_decode(6'(i), WIDE, LEGACY);
        fits  = !g.rsv && ((g[4:0] & ~want[4:0]) == 5'h00) && (!g.x || g.mode == want.mode);
        score = {2'h0, g.r} + {2'h0, g.w} + {2'h0, g.c} + {2'h0, g.x} + {2'h0, g.system_register_grant};
        if (fits && score > best) begin
          best = score;
          pick = 6'(i);
        end
      end
    end
    return pick;
  endfunction

  assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
  assign slot_idx = req_q.slot[SLOT_W-1:0];

  // Write address channel: hold one address until the response is issued
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      aw_addr_q     <= '0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q     <= 1'b1;
      aw_addr_q     <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else begin
      if (do_write) begin
        aw_have_q <= 1'b0;
      end
      s_axi_awready <= !aw_have_q && !s_axi_bvalid;
    end
  end

  // Write data channel: independent of the address, either may come first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q     <= 1'b0;
      w_data_q     <= '0;
      w_strb_q     <= '0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q     <= 1'b1;
      w_data_q     <= s_axi_wdata;
      w_strb_q     <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else begin
      if (do_write) begin
        w_have_q <= 1'b0;
      end
      s_axi_wready <= !w_have_q && !s_axi_bvalid;
    end
  end

  // Writable offsets: capability words and the request register
  assign wr_err = !((aw_addr_q < OFF_REQ) || (aw_addr_q[ADDR_W-1:WORD_LSB] == OFF_REQ[ADDR_W-1:WORD_LSB]));

  // Write response once both halves are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_err ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read decode; words above the capability width read as zero
  always_comb begin
    rd_data = '0;
    rd_err  = 1'b0;
    if (s_axi_araddr < OFF_REQ) begin
      for (int k = 0; k < NWORDS; k++) begin
        if (s_axi_araddr[WORD_LSB+:2] == 2'(k)) begin
          rd_data = cap_q[k*DATA_W+:DATA_W];
        end
      end
    end else begin
      case (s_axi_araddr[ADDR_W-1:WORD_LSB])
        OFF_REQ[ADDR_W-1:WORD_LSB]:    rd_data = req_q;
        OFF_STATUS[ADDR_W-1:WORD_LSB]: rd_data = status_q;
        OFF_CONFIG[ADDR_W-1:WORD_LSB]: rd_data = {15'h0000, LEGACY, 8'(CAP_W), 8'(MXLEN)};
        default:                       rd_err  = 1'b1;
      endcase
    end
  end

  // Read channel: one read in flight, answer one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_data;
      s_axi_rresp   <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // Request register; a write launches the operation on the next edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_q   <= '0;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      if (do_write && aw_addr_q[ADDR_W-1:WORD_LSB] == OFF_REQ[ADDR_W-1:WORD_LSB]) begin
        req_q   <= cpd_req_t'(w_data_q);
        start_q <= 1'b1;
      end
    end
  end

  // Grant decode and access check on the working capability
  always_comb begin
    ap_raw    = 6'(cap_q[CAP_W-1 -: AP_W]);
    grants    = cpd_decode(ap_raw, WIDE, LEGACY);
    usable    = cap_tag_q && !req_q.sealed && req_q.in_bounds && !cap_q[RSV_BIT] && !grants.rsv;
    is_access = 1'b1;
    case (req_q.op)
      OP_LOAD_DATA:  need_ok = grants.r;
      OP_STORE_DATA: need_ok = grants.w;
      OP_LOAD_CAP:   need_ok = grants.r && grants.c;
      OP_STORE_CAP:  need_ok = grants.w && grants.c;
      OP_FETCH:      need_ok = grants.x;
      OP_CSR:        need_ok = grants.system_register_grant;
      default: begin
        need_ok   = 1'b0;
        is_access = 1'b0;
      end
    endcase
    allowed = usable && need_ok;
    ap_new  = restrict_ap(ap_raw, req_q.keep_mask);
  end

  // Working capability: tagged root at reset, integer writes drop the tag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_q                  <= '0;
      cap_q[CAP_W-1 -: AP_W] <= ROOT_AP[AP_W-1:0];
      cap_tag_q              <= 1'b1;
    end else if (do_write && aw_addr_q < OFF_REQ) begin
      for (int k = 0; k < NWORDS; k++) begin
        for (int b = 0; b < STRB_W; b++) begin
          if (aw_addr_q[WORD_LSB+:2] == 2'(k) && w_strb_q[b]) begin
            cap_q[k*DATA_W+b*BYTE_W+:BYTE_W] <= w_data_q[b*BYTE_W+:BYTE_W];
          end
        end
      end
      if ({1'b0, aw_addr_q[WORD_LSB+:2]} < 3'(NWORDS) && |w_strb_q) begin
        cap_tag_q <= 1'b0;
      end
    end else if (start_q && req_q.op == OP_LOAD_CAP && allowed) begin
      cap_q     <= slot_q[slot_idx];
      cap_tag_q <= slot_tag_q[slot_idx];
    end else if (start_q && req_q.op == OP_RESTRICT) begin
      cap_q[CAP_W-1 -: AP_W] <= ap_new[AP_W-1:0];
      cap_tag_q <= cap_tag_q && !req_q.sealed && !cap_q[RSV_BIT];
    end
  end

  // Tagged memory slots; integer stores clear the whole slot tag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int s = 0; s < SLOTS; s++) begin
        slot_q[s]     <= '0;
        slot_tag_q[s] <= 1'b0;
      end
    end else if (start_q && allowed) begin
      if (req_q.op == OP_STORE_CAP) begin
        slot_q[slot_idx]     <= cap_q;
        slot_tag_q[slot_idx] <= cap_tag_q;
      end else if (req_q.op == OP_STORE_DATA && |req_q.byte_mask) begin
        slot_tag_q[slot_idx] <= 1'b0;
      end
    end
  end

  // Result status of the last operation
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= '0;
    end else if (do_write && aw_addr_q[ADDR_W-1:WORD_LSB] == OFF_REQ[ADDR_W-1:WORD_LSB]) begin
      status_q.done <= 1'b0;
    end else if (start_q) begin
      status_q.done    <= 1'b1;
      status_q.allowed <= allowed;
      status_q.fault   <= is_access && !allowed;
      status_q.grants  <= grants[5:0];
      status_q.ap      <= ap_raw;
      case (req_q.op)
        OP_LOAD_DATA: status_q.res_tag <= 1'b0;
        OP_LOAD_CAP:  status_q.res_tag <= allowed && slot_tag_q[slot_idx];
        OP_RESTRICT:  status_q.res_tag <= cap_tag_q && !req_q.sealed && !cap_q[RSV_BIT];
        default:      status_q.res_tag <= 1'b0;
      endcase
    end else begin
      status_q.cap_tag <= cap_tag_q;
    end
  end

  // Fault line follows the stored status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      access_fault <= 1'b0;
    end else if (start_q) begin
      access_fault <= is_access && !allowed;
    end
  end

endmodule
`default_nettype wire

//--- cpd_pkg.sv
// Package: constants and field layouts for the capability permission block
`default_nettype none
package cpd_pkg;

  // Register bus geometry
  localparam int          ADDR_W      = 6;
  localparam int          DATA_W      = 32;
  localparam int          BYTE_W      = 8;
  localparam int          STRB_W      = DATA_W / BYTE_W;
  localparam int          WORD_LSB    = 2;
  localparam int          MAX_WORDS   = 4;

  // Register byte offsets
  localparam logic [5:0]  OFF_CAP0    = 6'h00;
  localparam logic [5:0]  OFF_REQ     = 6'h10;
  localparam logic [5:0]  OFF_STATUS  = 6'h14;
  localparam logic [5:0]  OFF_CONFIG  = 6'h18;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Grant field widths and layout
  localparam int          AP_W32      = 5;
  localparam int          AP_W64      = 6;
  localparam int          AP_CODES32  = 32;
  localparam logic [1:0]  Q_DATA      = 2'h0;
  localparam logic [1:0]  Q_EXEC      = 2'h1;
  localparam logic [1:0]  Q_CAP       = 2'h3;
  localparam logic [5:0]  AP64_NOMODE = 6'h1F;
  localparam logic [5:0]  AP_ALL      = 6'h3F;

  // Root capability present after reset
  localparam logic [5:0]  ROOT_AP32   = 6'h09;
  localparam logic [5:0]  ROOT_AP64   = 6'h3F;

  // Tagged capability slots
  localparam int          SLOTS       = 16;

  // Operations carried by a request
  typedef enum logic [2:0] {
    OP_LOAD_DATA, OP_STORE_DATA, OP_LOAD_CAP, OP_STORE_CAP,
    OP_FETCH, OP_CSR, OP_RESTRICT, OP_READ_GRANTS
  } cpd_op_t;

  // Decoded grants; low six bits follow the one-bit-per-grant layout
  typedef struct packed {
    logic rsv;
    logic mode;
    logic system_register_grant;
    logic x;
    logic r;
    logic w;
    logic c;
  } cpd_grants_t;

  localparam cpd_grants_t GRANTS_NONE = 7'h00;
  localparam cpd_grants_t GRANTS_RSV  = 7'h40;

  // Request register layout
  typedef struct packed {
    logic [7:0] byte_mask;
    logic [1:0] pad2;
    logic [5:0] keep_mask;
    logic [3:0] pad1;
    logic [3:0] slot;
    logic [2:0] pad0;
    logic       in_bounds;
    logic       sealed;
    cpd_op_t    op;
  } cpd_req_t;

  // Status register layout
  typedef struct packed {
    logic [9:0] pad3;
    logic [5:0] ap;
    logic [1:0] pad2;
    logic [5:0] grants;
    logic [2:0] pad1;
    logic       cap_tag;
    logic       res_tag;
    logic       fault;
    logic       allowed;
    logic       done;
  } cpd_status_t;

endpackage
`default_nettype wire

//--- cpd_axi_master.sv
// Register-bus master standing in for the hart's access pipeline
`default_nettype none
module cpd_axi_master import cpd_pkg::*; (
  input  wire logic              aclk,
  output var  logic [ADDR_W-1:0] s_axi_awaddr,
  output var  logic              s_axi_awvalid,
  input  wire logic              s_axi_awready,
  output var  logic [DATA_W-1:0] s_axi_wdata,
  output var  logic [STRB_W-1:0] s_axi_wstrb,
  output var  logic              s_axi_wvalid,
  input  wire logic              s_axi_wready,
  input  wire logic [1:0]        s_axi_bresp,
  input  wire logic              s_axi_bvalid,
  output var  logic              s_axi_bready,
  output var  logic [ADDR_W-1:0] s_axi_araddr,
  output var  logic              s_axi_arvalid,
  input  wire logic              s_axi_arready,
  input  wire logic [DATA_W-1:0] s_axi_rdata,
  input  wire logic [1:0]        s_axi_rresp,
  input  wire logic              s_axi_rvalid,
  output var  logic              s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet bus at time zero
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end

  // One write; each half released on its own edge, payload inverted so stale data never looks live
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                    input logic [STRB_W-1:0] s, output logic [1:0] r);
    logic ta;
    logic tw;
    ta = 1'h0;
    tw = 1'h0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (!ta && s_axi_awready) begin
        ta = 1'h1;
        s_axi_awvalid <= 1'h0;
        s_axi_awaddr  <= ~a;
      end
      if (!tw && s_axi_wready) begin
        tw = 1'h1;
        s_axi_wvalid <= 1'h0;
        s_axi_wdata  <= ~d;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  // One read; data taken at the edge that sees rvalid
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    s_axi_araddr  <= ~a;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
endmodule
`default_nettype wire

//--- cpd_top_monitor.sv
// Bus and fault-timing checks bound to the permission block
`default_nettype none
module cpd_top_monitor import cpd_pkg::*; #(
  parameter int MXLEN  = 32,
  parameter bit LEGACY = 1'b1
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [STRB_W-1:0] s_axi_wstrb,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              access_fault
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Write answer two edges after acceptance, read answer one; both stand until taken
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer late");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  // Channels refuse while busy and free up on time; error reads carry zero data
  a_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while busy");
  a_ar_return: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##1 s_axi_arready)
    else $error("read channel not freed");
  a_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == '0)
    else $error("error read carries data");
  // Fault flag moves only after a request write
  a_fault_cause: assert property ($changed(access_fault) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("fault flag moved alone");

  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_rd_err: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  c_fault: cover property ($rose(access_fault));
endmodule

bind cpd_top cpd_top_monitor #(.MXLEN(MXLEN), .LEGACY(LEGACY)) u_mon (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .access_fault
);
`default_nettype wire

//--- cpd_tb.sv
// Self-checking bench for the capability permission block
`default_nettype none
module tb import cpd_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic              aclk, aresetn, access_fault, s_axi_bready, s_axi_rready;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, st, v;
  logic [STRB_W-1:0] s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, r;
  int                n_mismatch = 0;
  int                n_compared = 0;
  localparam logic [5:0] META = 6'h04;
  // Rows: code index in, grant flags {mode,asr,x,r,w,c} out
  localparam logic [5:0] EXP_G [AP_CODES32] = '{
    6'h00, 6'h04, 6'h00, 6'h00, 6'h02, 6'h06, 6'h00, 6'h00,
    6'h1F, 6'h3F, 6'h0D, 6'h2D, 6'h0F, 6'h2F, 6'h0E, 6'h2E,
    6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00,
    6'h00, 6'h00, 6'h00, 6'h05, 6'h00, 6'h00, 6'h00, 6'h07};

  cpd_top #(.MXLEN(32), .LEGACY(1'b1)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .access_fault);
  cpd_axi_master m (
    .aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  // 250 MHz clock
  initial aclk = 1'h0;
  always #2 aclk = ~aclk;

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic summarize;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Request word: byte mask, keep mask, slot, in-bounds, sealed, operation
  function automatic logic [31:0] rq(input cpd_op_t o, input logic sl, input logic ib,
                                     input logic [3:0] sn, input logic [5:0] kp, input logic [7:0] bm);
    return {bm, 2'h0, kp, 4'h0, sn, 3'h0, ib, sl, o};
  endfunction

  // Launch an operation, then fetch its status
  task automatic op(input logic [31:0] q);
    m.wr(OFF_REQ, q, 4'hF, r);
    m.rd(OFF_STATUS, st, r);
  endtask

  // Hold reset for n edges, checking outputs inside and readies after
  task automatic do_reset(input int n);
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (n) @(posedge aclk);
    #1;
    chk("outputs in reset", {s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid, access_fault}, 0);
    @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    #1;
    chk("readies after reset", {s_axi_awready, s_axi_wready, s_axi_arready}, 3'h7);
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge aclk);
    n_mismatch++;
    summarize();
  end

  initial begin
    aresetn = 1'h0;
    do_reset(10); // Low for 12 edges counting the task's framing edges
    for (int i = 0; i < AP_CODES32; i++) begin
      m.wr(META, 32'(i) << 27, 4'hF, r);
      op(rq(OP_READ_GRANTS, 0, 1, 0, 6'h3F, 0));
      chk("grants", st[13:8], EXP_G[i]);
    end
    chk("tag after write", st[4], 0);
    $display("test decode done");
    // Root capability, register map and refusals
    do_reset(2);
    m.rd(OFF_CONFIG, v, r);
    chk("config", v, 32'h0001_4020);
    m.rd(META, v, r);
    chk("root metadata", v, 32'h4800_0000);
    m.rd(OFF_CAP0, v, r);
    chk("root address", v, 32'h0);
    m.rd(6'h1C, v, r);
    chk("unmapped read", r, RESP_SLVERR);
    m.wr(OFF_STATUS, 32'h0, 4'hF, r);
    chk("status write", r, RESP_SLVERR);
    $display("test registers done");
    // Access checks with the tagged root, then with the untagged capability loaded back from slot 2
    op(rq(OP_FETCH, 0, 1, 0, 0, 0));
    chk("fetch", st[2:0], 3'h3);
    op(rq(OP_CSR, 0, 1, 0, 0, 0));
    chk("csr", st[2:0], 3'h3);
    op(rq(OP_FETCH, 1, 1, 0, 0, 0));
    chk("sealed fetch", st[2:0], 3'h5);
    chk("fault pin", access_fault, 1);
    op(rq(OP_LOAD_DATA, 0, 0, 0, 0, 0));
    chk("out of bounds", st[2:0], 3'h5);
    op(rq(OP_LOAD_DATA, 0, 1, 0, 0, 0));
    chk("data load", st[3:0], 4'h3);
    chk("fault pin", access_fault, 0);
    op(rq(OP_STORE_CAP, 0, 1, 4'h2, 0, 0));
    chk("cap store", st[2:0], 3'h3);
    op(rq(OP_LOAD_CAP, 0, 1, 4'h2, 0, 0));
    chk("tagged cap load", st[3:0], 4'hB);
    op(rq(OP_STORE_DATA, 0, 1, 4'h2, 0, 8'h01));
    chk("data store", st[2:0], 3'h3);
    op(rq(OP_LOAD_CAP, 0, 1, 4'h2, 0, 0));
    chk("cap load", st[2:0], 3'h3);
    op(rq(OP_FETCH, 0, 1, 0, 0, 0));
    chk("fetch untagged", st[2:0], 3'h5);
    op(rq(OP_RESTRICT, 0, 1, 0, 6'h3F, 0));
    chk("restrict untagged", st[3], 0);
    $display("test access done");
    // Fresh root with the capability grant removed
    do_reset(2);
    op(rq(OP_RESTRICT, 0, 1, 0, 6'h3E, 0));
    chk("restrict tag", st[3], 1);
    m.rd(META, v, r);
    chk("restricted field", v, 32'h7800_0000);
    op(rq(OP_LOAD_CAP, 0, 1, 4'h1, 0, 0));
    chk("cap load no grant", st[2:0], 3'h5);
    op(rq(OP_STORE_CAP, 0, 1, 4'h1, 0, 0));
    chk("cap store no grant", st[2:0], 3'h5);
    op(rq(OP_FETCH, 0, 1, 0, 0, 0));
    chk("fetch kept", st[2:0], 3'h3);
    $display("test restrict done");
    summarize();
  end
endmodule
`default_nettype wire
